// ### tb/hac_bus_master.sv
`timescale 1ns/10ps
module hac_bus_master
(
  input  wire clock,
  input  wire sda_line,
  output reg  scl,
  output reg  sda
);
  initial {scl, sda} = 2'b11;
  task w(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // Data moves one clock after the clock falls, so it is never mistaken for a start or stop.
  task frame(input [7:0] a, input [7:0] d, output [1:0] ak);
    integer        i;
    reg     [15:0] v;
    v = {a, d};
    sda <= 1'b0;
    w(4);
    scl <= 1'b0;
    for (i = 0; i < 18; i = i + 1)
    begin
      w(1);
      sda <= (i % 9 == 8) ? 1'b1 : v[15 - i + i / 9];
      w(3);
      scl <= 1'b1;
      w(2);
      if (i % 9 == 8)
        ak[1 - i / 9] = ~sda_line;
      w(2);
      scl <= 1'b0;
    end
    w(1);
    sda <= 1'b0;
    w(3);
    scl <= 1'b1;
    w(4);
    sda <= 1'b1;
    w(4);
  endtask
endmodule

// ### tb/hac_chk_assertions.sv
`timescale 1ns/10ps
module hac_chk
(
  input wire       clock,
  input wire       rst,
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe_n,
  input wire [6:0] channel_mode_reg,
  input wire [6:0] gain_level_reg,
  input wire       left_channel_on,
  input wire       right_channel_on,
  input wire       bias_on,
  input wire       right_into_left,
  input wire [5:0] gain_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence ack_held; (!sda_oe_n) [*4]; endsequence
  a_ack_held: assert property ($fell(sda_oe_n) |-> ack_held) else $error("ack short");
  a_ack_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in) else $error("ack late");
  a_sda_low: assert property (!sda_out) else $error("sda high");
  a_bit3_zero: assert property (!channel_mode_reg[3]) else $error("bit3 set");
  a_left_off: assert property (channel_mode_reg[6] |-> !left_channel_on) else $error("left on");
  a_pump_off: assert property (channel_mode_reg[4] |-> !(left_channel_on | right_channel_on | bias_on))
    else $error("amp on");
  a_right_sum: assert property (channel_mode_reg[1] && !channel_mode_reg[4] && !channel_mode_reg[6]
    && !gain_level_reg[6] |-> right_into_left && !right_channel_on) else $error("no sum");
  a_gain_code: assert property (gain_code == gain_level_reg[5:0]) else $error("bad code");
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  reg        clock = 1'b0;
  reg        rst = 1'b1;
  reg        en = 1'b1;
  reg  [1:0] ak;
  wire       scl, msda, sda_out, sda_oe_n, lon, ron, bon, pon, ril, lm, rm, gs;
  wire [6:0] mode, gain;
  wire [5:0] code;
  wire       sda = msda & (sda_oe_n | sda_out);
  integer    mismatches = 0;
  integer    checks_done = 0;
  always #20 clock = ~clock;
  hac_bus_master m (.clock(clock), .sda_line(sda), .scl(scl), .sda(msda));
  hac_i2c_control dut (.clock(clock), .rst(rst), .clk_en(en), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .channel_mode_reg(mode), .gain_level_reg(gain),
    .left_channel_on(lon), .right_channel_on(ron), .bias_on(bon), .pump_on(pon), .right_into_left(ril),
    .left_muted(lm), .right_muted(rm), .gain_code(code), .gain_silent(gs));
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task t_mode;
    m.frame(8'hc0, 8'h10, ak);
    chk("pump", {ak, lon, ron, bon, pon}, 8'h31);
    m.frame(8'hc0, 8'h7f, ak);
    chk("mode", mode, 8'h77);
    chk("mute", {lm, rm, lon}, 8'h06);
    $display("mode done");
  endtask
  task t_gain;
    m.frame(8'hc0, 8'hc0, ak);
    chk("down", {gain, pon}, 8'h80);
    m.frame(8'hc0, 8'h80, ak);
    chk("silent", {gs, code}, 8'h40);
    m.frame(8'hc0, 8'hbf, ak);
    chk("loud", {mode, gs}, 8'hee);
    $display("gain done");
  endtask
  task t_refuse;
    m.frame(8'hc1, 8'h81, ak);
    chk("read", {ak, code}, 8'h3f);
    m.frame(8'he0, 8'h00, ak);
    chk("other", {ak, mode[5:0]}, 8'h37);
    $display("refuse done");
  endtask
  task t_sum;
    m.frame(8'hc0, 8'h02, ak);
    chk("sum", {ril, lon, ron, bon}, 8'h0d);
    $display("sum done");
  endtask
  task t_freeze;
    en <= 1'b0;
    m.frame(8'hc0, 8'h7f, ak);
    chk("freeze", {ak, mode[5:0]}, 8'h02);
    en <= 1'b1;
    repeat (4) @(posedge clock);
    $display("freeze done");
  endtask
  task t_reset;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("rerun", {gain, lon}, 8'h01);
    m.frame(8'hc0, 8'h85, ak);
    chk("after", {ak, code}, 8'hc5);
    $display("reset done");
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("reset", {mode, sda_oe_n}, 8'h01);
    t_mode;
    t_gain;
    t_refuse;
    t_sum;
    t_freeze;
    t_reset;
    complete_run;
  end
  initial
  begin
    #400000;
    mismatches = mismatches + 1;
    complete_run;
  end
endmodule
bind hac_i2c_control hac_chk u_chk (.*);

// ### verilog/hac_i2c_control.v
`timescale 1ns/10ps
// Overview of operation
// (R01) Slave only; the serial clock is an input and never driven.
// (R02) Works at serial clock rates up to 400 kHz.
// (R03) Master keeps data steady while clock high, except start/stop.
// (R04) Master frames every transaction with start and stop.
// (R05) Data falling while clock high is a start; address byte follows.
// (R06) Every byte is eight bits followed by one acknowledge clock.
// (R07) Master sends seven address bits MSB first, then direction bit.
// (R08) Only address 1100000 (first byte 0xc0) is answered.
// (R09) Read transfers are neither acknowledged nor answered.
// (R10) Each bit is sampled on the rising serial clock edge.
// (R11) Master releases data during every acknowledge clock.
// (R12) Matching address is acknowledged by pulling data low.
// (R13) One data byte follows the address and is acknowledged low.
// (R14) Master ends with stop: data rises while clock high.
// (R15) Bit 7 selects mode or gain register; bits 6..0 are stored.
// (R16) Mode bits: left off, bias off, left mute, right mute; bit 3 zero.
// (R17) Right-off bit disables right and sums right into left output.
// (R18) Pump-only bit disables amplifiers and bias; pump keeps running.
// (R19) Pump-only disables both channels whatever the shutdown bits.
// (R20) Six-bit gain code maps monotonically; 0 is -96 dB, 1 is -60 dB.
// (R21) Address mismatch leaves data released, ignores bits until next start.
// (R22) A data byte commits only after it is received and acknowledged.
`include "hac_map.vh"

module hac_i2c_control
(
  input  wire       clock,
  input  wire       rst,
  input  wire       clk_en,
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe_n,
  output reg  [6:0] channel_mode_reg,
  output reg  [6:0] gain_level_reg,
  output wire       left_channel_on,
  output wire       right_channel_on,
  output wire       bias_on,
  output wire       pump_on,
  output wire       right_into_left,
  output wire       left_muted,
  output wire       right_muted,
  output wire [5:0] gain_code,
  output wire       gain_silent
);

  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_ADDR     = 3'h1;
  localparam [2:0] ST_ADDR_ACK = 3'h2;
  localparam [2:0] ST_ADDR_HLD = 3'h3;
  localparam [2:0] ST_DATA     = 3'h4;
  localparam [2:0] ST_DATA_ACK = 3'h5;
  localparam [2:0] ST_DATA_HLD = 3'h6;
  localparam [2:0] ST_WAIT     = 3'h7;

  wire [1:0] pin_raw;
  wire [1:0] pin_sync;
  wire [1:0] pin_prev;
  reg  [2:0] state;
  reg  [2:0] bit_cnt;
  reg  [7:0] shift;
  reg        ack_drive;
  reg  [7:0] data_hold;
  reg  [2:0] next_state;
  reg  [2:0] next_bit_cnt;
  reg  [7:0] next_shift;
  reg        next_ack;
  reg  [7:0] next_hold;
  reg  [6:0] next_mode;
  reg  [6:0] next_gain;
  reg        left_on_q;
  reg        right_on_q;
  reg        bias_on_q;
  reg        pump_on_q;
  reg        sum_q;
  reg        left_mute_q;
  reg        right_mute_q;
  reg  [5:0] code_q;
  reg        silent_q;

  function addr_match;
    input [7:0] sh;
    begin
      addr_match = (sh == {`HAC_DEV_ADDR, 1'b0}); // R08 R09
    end
  endfunction

  function is_bit_state;
    input [2:0] st;
    begin
      is_bit_state = (st == ST_ADDR) || (st == ST_DATA);
    end
  endfunction

  // Pump-only and global power down override every per-channel switch.
  function chan_on;
    input [6:0] mode;
    input [6:0] gain;
    input       off_bit;
    begin
      chan_on = ~gain[`HAC_GAIN_POWER_DOWN] & ~mode[`HAC_MODE_PUMP_ONLY] & ~off_bit; // R18 R19
    end
  endfunction

  function [6:0] mode_clean;
    input [6:0] bits;
    begin
      mode_clean = bits & ~(7'h01 << `HAC_MODE_UNUSED); // R16
    end
  endfunction

  assign pin_raw = {sda_in, scl_in};

  // Sampling at 25 MHz gives about 62 clocks per 400 kHz bit, far above the sync delay.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_sync
      reg stage_a;
      reg stage_b;
      reg stage_c;
      always @(posedge clock)
      begin
        if (rst)
        begin
          stage_a <= 1'b1;
          stage_b <= 1'b1;
          stage_c <= 1'b1;
        end
        else if (clk_en)
        begin
          stage_a <= pin_raw[g]; // R02
          stage_b <= stage_a;
          stage_c <= stage_b;
        end
      end
      assign pin_sync[g] = stage_b;
      assign pin_prev[g] = stage_c;
    end
  endgenerate

  wire scl_s      = pin_sync[0];
  wire sda_s      = pin_sync[1];
  wire scl_p      = pin_prev[0];
  wire sda_p      = pin_prev[1];
  wire scl_rise   = scl_s & ~scl_p; // R10
  wire scl_fall   = ~scl_s & scl_p;
  wire start_cond = scl_s & scl_p & sda_p & ~sda_s; // R05
  wire stop_cond  = scl_s & scl_p & ~sda_p & sda_s; // R14

  // Acknowledge is driven from one falling edge to the next, so the master samples it while high.
  always @*
  begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    next_ack     = ack_drive;
    next_hold    = data_hold;
    next_mode    = channel_mode_reg;
    next_gain    = gain_level_reg;
    if (start_cond)
    begin
      next_state   = ST_ADDR; // R05
      next_bit_cnt = 3'h0;
      next_ack     = 1'b0;
    end
    else if (stop_cond)
    begin
      next_state = ST_IDLE;
      next_ack   = 1'b0;
    end
    else
    begin
      if (is_bit_state(state) && scl_rise)
      begin
        next_shift   = {shift[6:0], sda_s}; // R10
        next_bit_cnt = bit_cnt + 3'h1;
      end
      case (state)
        ST_ADDR:
        begin
          if (scl_rise && bit_cnt == 3'h7)
          begin
            next_state = ST_ADDR_ACK; // R06
          end
        end
        ST_DATA:
        begin
          if (scl_rise && bit_cnt == 3'h7)
          begin
            next_state = ST_DATA_ACK; // R06
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (addr_match(shift)) // R08 R09
            begin
              next_ack   = 1'b1; // R12
              next_state = ST_ADDR_HLD;
            end
            else
            begin
              next_state = ST_WAIT; // R21
            end
          end
        end
        ST_ADDR_HLD:
        begin
          if (scl_fall)
          begin
            next_ack     = 1'b0;
            next_bit_cnt = 3'h0;
            next_state   = ST_DATA;
          end
        end
        ST_DATA_ACK:
        begin
          if (scl_fall)
          begin
            next_ack   = 1'b1; // R13
            next_hold  = shift;
            next_state = ST_DATA_HLD;
          end
        end
        ST_DATA_HLD:
        begin
          if (scl_fall)
          begin
            next_ack   = 1'b0;
            next_state = ST_WAIT;
            if (data_hold[`HAC_SEL_BIT]) // R15 R22
            begin
              next_gain = data_hold[6:0];
            end
            else
            begin
              next_mode = mode_clean(data_hold[6:0]); // R16
            end
          end
        end
        ST_WAIT:
        begin
          next_state = ST_WAIT; // R21
        end
        ST_IDLE:
        begin
          next_state = ST_IDLE;
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Decoded levels are taken from the next register values so they change on the same edge.
  always @(posedge clock)
  begin
    if (rst)
    begin
      state            <= ST_IDLE;
      bit_cnt          <= 3'h0;
      shift            <= 8'h00;
      ack_drive        <= 1'b0;
      data_hold        <= 8'h00;
      channel_mode_reg <= `HAC_MODE_RESET;
      gain_level_reg   <= `HAC_GAIN_RESET;
      left_on_q        <= 1'b1;
      right_on_q       <= 1'b1;
      bias_on_q        <= 1'b1;
      pump_on_q        <= 1'b1;
      sum_q            <= 1'b0;
      left_mute_q      <= 1'b0;
      right_mute_q     <= 1'b0;
      code_q           <= 6'h00;
      silent_q         <= 1'b1;
    end
    else if (clk_en)
    begin
      state            <= next_state;
      bit_cnt          <= next_bit_cnt;
      shift            <= next_shift;
      ack_drive        <= next_ack;
      data_hold        <= next_hold;
      channel_mode_reg <= next_mode;
      gain_level_reg   <= next_gain;
      left_on_q        <= chan_on(next_mode, next_gain, next_mode[`HAC_MODE_LEFT_OFF]); // R19
      right_on_q       <= chan_on(next_mode, next_gain, next_mode[`HAC_MODE_RIGHT_OFF]); // R17 R19
      bias_on_q        <= chan_on(next_mode, next_gain, next_mode[`HAC_MODE_BIAS_OFF]); // R16 R18
      pump_on_q        <= ~next_gain[`HAC_GAIN_POWER_DOWN]; // R18
      sum_q            <= chan_on(next_mode, next_gain, next_mode[`HAC_MODE_LEFT_OFF])
                          & next_mode[`HAC_MODE_RIGHT_OFF]; // R17
      left_mute_q      <= next_mode[`HAC_MODE_MUTE_LEFT]; // R16
      right_mute_q     <= next_mode[`HAC_MODE_MUTE_RIGHT]; // R16
      code_q           <= next_gain[5:0]; // R20
      silent_q         <= (next_gain[5:0] == 6'h00); // R20
    end
  end

  assign sda_out  = 1'b0; // R01
  assign sda_oe_n = ~ack_drive; // R12 R21

  assign pump_on          = pump_on_q;
  assign bias_on          = bias_on_q;
  assign left_channel_on  = left_on_q;
  assign right_channel_on = right_on_q;
  assign right_into_left  = sum_q;
  assign left_muted       = left_mute_q;
  assign right_muted      = right_mute_q;
  assign gain_code        = code_q;
  assign gain_silent      = silent_q;

endmodule

// ### verilog/hac_map.vh
`ifndef HAC_MAP_VH
`define HAC_MAP_VH
`define HAC_DEV_ADDR          7'h60
`define HAC_REG_MODE          1'h0
`define HAC_REG_GAIN          1'h1
`define HAC_SEL_BIT           7
`define HAC_MODE_LEFT_OFF     6
`define HAC_MODE_BIAS_OFF     5
`define HAC_MODE_PUMP_ONLY    4
`define HAC_MODE_UNUSED       3
`define HAC_MODE_MUTE_LEFT    2
`define HAC_MODE_RIGHT_OFF    1
`define HAC_MODE_MUTE_RIGHT   0
`define HAC_GAIN_POWER_DOWN   6
`define HAC_MODE_RESET        7'h00
`define HAC_GAIN_RESET        7'h00
`define HAC_MAX_SCL_KHZ       400
`define HAC_CLK_MHZ           25
`define HAC_MIN_SCL_CYCLES    ((`HAC_CLK_MHZ * 1000) / `HAC_MAX_SCL_KHZ)
`endif
